// >>> verilog/bsl_top.sv
`timescale 1ns/1ps
`include "bsl_consts.svh"

module bsl_top
#(
   parameter int unsigned BLINK_HALF_CYC =
      `BSL_BLINK_HALF_MS * `BSL_CLK_KHZ,
   parameter int unsigned STAGGER_CYC = `BSL_STAGGER_MS * `BSL_CLK_KHZ
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] slot_position_inputs,
   input wire logic [47:0] port_mac_addr,
   input wire bsl_pkg::bsl_hs_t hotswap,
   input wire bsl_pkg::bsl_fail_t failure,
   input wire bsl_pkg::bsl_link_t cable_link,
   input wire bsl_pkg::bsl_link_t fibre_link,
   input wire logic rd_en,
   input wire logic [11:0] rd_addr,
   output logic [31:0] rd_data_q,
   output logic rd_valid_q,
   output logic cfg_wr_q,
   output logic [11:0] cfg_addr_q,
   output logic [31:0] cfg_data_q,
   output logic startup_done_q,
   output logic removal_led_q,
   output logic failure_led_q,
   output logic cable_link_indicator_q,
   output logic fibre_link_indicator_q
);
   import bsl_pkg::*;

   bsl_top_st_t s_q;
   bsl_top_st_t s_d;
   logic blink_ph;
   logic blink_tick;
   logic fail_unknown;

   // Shared by the config-memory writer and the software read port
   function automatic logic [31:0] sn_word(input logic [11:0] a,
      input logic [3:0] ga, input logic [47:0] mac);
      logic [31:0] w;
      w = `BSL_WORD_NONE;
      if (a == `BSL_OFS_SN_LO)
         w = {mac[23:0], `BSL_SN_LO_RSV, ga};
      else if (a == `BSL_OFS_SN_HI)
         w = {mac[47:24], `BSL_SN_HI_RSV};
      return w;
   endfunction

   function automatic logic link_led(input bsl_link_t l, input logic ph);
      return l.up & (l.gen3 | ph);
   endfunction

   bsl_blink
   #(
      .HALF_CYC(BLINK_HALF_CYC)
   )
   u_blink
   (
      .clk(clk),
      .rst(rst),
      .phase_q(blink_ph),
      .tick_q(blink_tick)
   );

   // Code zero cannot be counted out, so it is shown as unknown
   assign fail_unknown = ~failure.known | (failure.code == 4'h0);

   always_comb
   begin
      s_d = s_q;
      // Pin synchroniser; only stages two and three are compared
      s_d.ga_s1 = slot_position_inputs;
      s_d.ga_s2 = s_q.ga_s1;
      s_d.ga_s3 = s_q.ga_s2;
      s_d.cfg_wr = 1'b0;

      unique case (s_q.phase)
         BSL_ST_SETTLE:
         begin
            if (s_q.wait_cnt >= `BSL_SETTLE_CYC &&
                s_q.ga_s2 == s_q.ga_s3)
            begin
               s_d.ga_cap = s_q.ga_s3;
               s_d.slots_left = s_q.ga_s3;
               s_d.wait_cnt = 32'h0000_0000;
               s_d.phase = BSL_ST_STAGGER;
            end
            else
            begin
               s_d.wait_cnt = 32'(s_q.wait_cnt + 32'h0000_0001);
            end
         end
         BSL_ST_STAGGER:
         begin
            // Wait ga times one stagger slice, no multiplier needed
            if (s_q.slots_left == 4'h0)
            begin
               s_d.phase = BSL_ST_WR_LO;
            end
            else if (s_q.wait_cnt == 32'(STAGGER_CYC - 1))
            begin
               s_d.wait_cnt = 32'h0000_0000;
               s_d.slots_left = 4'(s_q.slots_left - 4'h1);
            end
            else
            begin
               s_d.wait_cnt = 32'(s_q.wait_cnt + 32'h0000_0001);
            end
         end
         BSL_ST_WR_LO:
         begin
            s_d.cfg_wr = 1'b1;
            s_d.cfg_addr = `BSL_OFS_SN_LO;
            s_d.cfg_data = sn_word(`BSL_OFS_SN_LO, s_q.ga_cap,
               port_mac_addr);
            s_d.phase = BSL_ST_WR_HI;
         end
         BSL_ST_WR_HI:
         begin
            s_d.cfg_wr = 1'b1;
            s_d.cfg_addr = `BSL_OFS_SN_HI;
            s_d.cfg_data = sn_word(`BSL_OFS_SN_HI, s_q.ga_cap,
               port_mac_addr);
            s_d.phase = BSL_ST_RUN;
         end
         BSL_ST_RUN:
         begin
            s_d.startup_done = 1'b1;
         end
      endcase

      // Read only: there is no write path into the stored words
      s_d.rd_valid = rd_en;
      s_d.rd_data = rd_en ?
         sn_word(rd_addr, s_q.ga_cap, port_mac_addr) : `BSL_WORD_NONE;

      s_d.removal_led = hotswap.prep ? blink_ph : hotswap.safe;
      s_d.cable_led = link_led(cable_link, blink_ph);
      s_d.fibre_led = link_led(fibre_link, blink_ph);

      if (!failure.valid)
      begin
         s_d.err_lit = 1'b0;
         s_d.flash_cnt = 4'h0;
         s_d.pause_cnt = 4'h0;
         s_d.failure_led = 1'b0;
      end
      else if (fail_unknown)
      begin
         s_d.err_lit = 1'b0;
         s_d.flash_cnt = 4'h0;
         s_d.pause_cnt = 4'h0;
         s_d.failure_led = 1'b1;
      end
      else
      begin
         if (blink_tick)
         begin
            if (s_q.pause_cnt != 4'h0)
            begin
               s_d.pause_cnt = 4'(s_q.pause_cnt - 4'h1);
            end
            else if (!s_q.err_lit)
            begin
               // Code lowered mid-burst: close it, never overshoot
               if (s_q.flash_cnt >= failure.code)
               begin
                  s_d.flash_cnt = 4'h0;
                  s_d.pause_cnt = `BSL_PAUSE_HALVES;
               end
               else
               begin
                  s_d.err_lit = 1'b1;
               end
            end
            else
            begin
               s_d.err_lit = 1'b0;
               if (4'(s_q.flash_cnt + 4'h1) >= failure.code)
               begin
                  s_d.flash_cnt = 4'h0;
                  s_d.pause_cnt = `BSL_PAUSE_HALVES;
               end
               else
               begin
                  s_d.flash_cnt = 4'(s_q.flash_cnt + 4'h1);
               end
            end
         end
         s_d.failure_led = s_d.err_lit;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.phase <= BSL_ST_SETTLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data_q = s_q.rd_data;
   assign rd_valid_q = s_q.rd_valid;
   assign cfg_wr_q = s_q.cfg_wr;
   assign cfg_addr_q = s_q.cfg_addr;
   assign cfg_data_q = s_q.cfg_data;
   assign startup_done_q = s_q.startup_done;
   assign removal_led_q = s_q.removal_led;
   assign failure_led_q = s_q.failure_led;
   assign cable_link_indicator_q = s_q.cable_led;
   assign fibre_link_indicator_q = s_q.fibre_led;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_removal_dark: assert property (
      !hotswap.prep && !hotswap.safe |=> !removal_led_q)
      else $error("removal indicator lit while removal not allowed");
   chk_removal_steady: assert property (
      !hotswap.prep && hotswap.safe |=> removal_led_q)
      else $error("removal indicator not steady when safe");
   chk_removal_flash: assert property (
      hotswap.prep |=> removal_led_q == $past(blink_ph))
      else $error("removal indicator not following flash phase");
   chk_fail_dark: assert property (
      !failure.valid |=> !failure_led_q)
      else $error("failure indicator lit without failure");
   chk_fail_steady: assert property (
      failure.valid && fail_unknown |=> failure_led_q)
      else $error("failure indicator not steady on unknown failure");
   chk_burst_count: assert property (
      $rose(s_q.err_lit) |-> s_q.flash_cnt < $past(failure.code))
      else $error("error burst exceeds code count");
   chk_pause_dark: assert property (
      s_q.pause_cnt != 4'h0 |-> !s_q.err_lit)
      else $error("failure indicator lit during burst pause");
   chk_link_gen3: assert property (
      cable_link.up && cable_link.gen3 |=> cable_link_indicator_q)
      else $error("cable indicator not steady at 8 Gb/s");
   chk_link_gen2: assert property (
      fibre_link.up && !fibre_link.gen3
      |=> fibre_link_indicator_q == $past(blink_ph))
      else $error("fibre indicator not flashing at 5 Gb/s");
   chk_wr_pair: assert property (
      cfg_wr_q && cfg_addr_q == `BSL_OFS_SN_LO
      |=> cfg_wr_q && cfg_addr_q == `BSL_OFS_SN_HI ##1 !cfg_wr_q)
      else $error("serial words not written as a pair");
   chk_lo_word: assert property (
      cfg_wr_q && cfg_addr_q == `BSL_OFS_SN_LO
      |-> cfg_data_q[3:0] == s_q.ga_cap && cfg_data_q[7:4] == 4'h0)
      else $error("low serial word slot field wrong");
   chk_stagger_hold: assert property (
      s_q.phase != BSL_ST_RUN |-> !startup_done_q && !$past(cfg_wr_q, 3))
      else $error("startup released before stagger done");
   chk_read_lo: assert property (
      rd_en && rd_addr == `BSL_OFS_SN_LO
      |=> rd_valid_q && rd_data_q[3:0] == $past(s_q.ga_cap))
      else $error("slot position not readable at low word");

   cov_burst: cover property (
      failure.valid && !fail_unknown && failure.code == 4'h3
      && s_q.pause_cnt == `BSL_PAUSE_HALVES);
   cov_cfg_write: cover property (cfg_wr_q ##1 cfg_wr_q ##1 startup_done_q);
   cov_remove_flash: cover property (hotswap.prep && $rose(removal_led_q));

endmodule

// >>> verilog/bsl_consts.svh
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH

// Clock rate in kHz, so that a time in ms times this is a cycle count
`define BSL_CLK_KHZ 50000
// Half period of every flashing indicator (about 4 Hz toggle, 2 Hz blink)
`define BSL_BLINK_HALF_MS 250
// Startup stagger per slot position
`define BSL_STAGGER_MS 20
// Cycles after reset before the slot position is trusted
`define BSL_SETTLE_CYC 32'h0000_0010
// Dark half periods between two error bursts, beyond the usual one between flashes
`define BSL_PAUSE_HALVES 4'h6

`define BSL_OFS_SN_LO 12'h104
`define BSL_OFS_SN_HI 12'h108
`define BSL_SN_LO_RSV 4'h0
`define BSL_SN_HI_RSV 8'h00
`define BSL_WORD_NONE 32'h0000_0000

`endif

// >>> verilog/bsl_pkg.sv
package bsl_pkg;

   typedef enum logic [4:0]
   {
      BSL_ST_SETTLE  = 5'h01,
      BSL_ST_STAGGER = 5'h02,
      BSL_ST_WR_LO   = 5'h04,
      BSL_ST_WR_HI   = 5'h08,
      BSL_ST_RUN     = 5'h10
   } bsl_phase_t;

   typedef struct packed
   {
      logic up;
      logic gen3;
   } bsl_link_t;

   typedef struct packed
   {
      logic prep;
      logic safe;
   } bsl_hs_t;

   typedef struct packed
   {
      logic valid;
      logic known;
      logic [3:0] code;
   } bsl_fail_t;

   typedef struct packed
   {
      logic [31:0] cnt;
      logic phase;
      logic tick;
   } bsl_blink_st_t;

   typedef struct packed
   {
      logic [3:0] ga_s1;
      logic [3:0] ga_s2;
      logic [3:0] ga_s3;
      logic [3:0] ga_cap;
      bsl_phase_t phase;
      logic [31:0] wait_cnt;
      logic [3:0] slots_left;
      logic cfg_wr;
      logic [11:0] cfg_addr;
      logic [31:0] cfg_data;
      logic startup_done;
      logic [31:0] rd_data;
      logic rd_valid;
      logic removal_led;
      logic failure_led;
      logic cable_led;
      logic fibre_led;
      logic err_lit;
      logic [3:0] flash_cnt;
      logic [3:0] pause_cnt;
   } bsl_top_st_t;

endpackage

// >>> verilog/bsl_blink.sv
`timescale 1ns/1ps
`include "bsl_consts.svh"

module bsl_blink
#(
   parameter int unsigned HALF_CYC = `BSL_BLINK_HALF_MS * `BSL_CLK_KHZ
)
(
   input wire logic clk,
   input wire logic rst,
   output logic phase_q,
   output logic tick_q
);
   import bsl_pkg::*;

   bsl_blink_st_t s_q;
   bsl_blink_st_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 32'(HALF_CYC - 1))
      begin
         s_d.cnt = 32'h0000_0000;
         s_d.phase = ~s_q.phase;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = 32'(s_q.cnt + 32'h0000_0001);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign phase_q = s_q.phase;
   assign tick_q = s_q.tick;

endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
   import bsl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] slot = 4'h0;
   logic [47:0] mac = 48'h0;
   bsl_hs_t hs = '0;
   bsl_fail_t fl = '0;
   bsl_link_t cl = '0;
   bsl_link_t fo = '0;
   logic rd_en = 1'b0;
   logic [11:0] rd_addr = 12'h000;
   logic [31:0] rd_data_q;
   logic [31:0] cfg_data_q;
   logic [11:0] cfg_addr_q;
   logic rd_valid_q;
   logic cfg_wr_q;
   logic startup_done_q;
   wire [3:0] led;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int t0 = 0;
   int t_lo = 0;
   logic [31:0] rq[$];
   logic [43:0] wq[$];

   always #10 clk = ~clk;

   // Short counts keep every blink and stagger period within a few cycles
   bsl_top #(.BLINK_HALF_CYC(4), .STAGGER_CYC(3)) dut
   (
      .clk(clk),
      .rst(rst),
      .slot_position_inputs(slot),
      .port_mac_addr(mac),
      .hotswap(hs),
      .failure(fl),
      .cable_link(cl),
      .fibre_link(fo),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q),
      .cfg_wr_q(cfg_wr_q),
      .cfg_addr_q(cfg_addr_q),
      .cfg_data_q(cfg_data_q),
      .startup_done_q(startup_done_q),
      .removal_led_q(led[3]),
      .failure_led_q(led[2]),
      .cable_link_indicator_q(led[1]),
      .fibre_link_indicator_q(led[0])
   );

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task summarize;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task step;
      @(posedge clk);
      #1;
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      step;
      rd_en = 1'b1;
      rd_addr = a;
      rq.push_back(e);
   endtask

   // Counts lit cycles and rising edges over n samples
   task meas(input int idx, input int n, output int lit, output int rises);
      logic prev;
      lit = 0;
      rises = 0;
      step;
      prev = led[idx];
      repeat (n)
      begin
         step;
         if (led[idx] === 1'b1)
            lit++;
         if (led[idx] === 1'b1 && prev !== 1'b1)
            rises++;
         prev = led[idx];
      end
   endtask

   // A full 32-cycle window holds four blink periods: flash = 16 lit
   task led_chk(input int idx, input int e);
      int l;
      int r;
      repeat (2) step;
      meas(idx, 32, l, r);
      check(l, e);
   endtask

   task boot(input logic [3:0] s);
      int k;
      slot = s;
      mac = 48'({$urandom, $urandom});
      wq.push_back({12'h104, mac[23:0], 4'h0, s});
      wq.push_back({12'h108, mac[47:24], 8'h00});
      step;
      rst = 1'b1;
      repeat (4) step;
      check({rd_data_q | cfg_data_q, cfg_addr_q, rd_valid_q, cfg_wr_q,
         startup_done_q, led}, 64'h0);
      rst = 1'b0;
      t0 = cyc;
      rd(12'h104, {mac[23:0], 8'h00});
      step;
      rd_en = 1'b0;
      k = 0;
      while (startup_done_q !== 1'b1 && k < 300)
      begin
         step;
         k++;
      end
      check(k < 300, 1'b1);
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (rd_valid_q === 1'b1)
      begin
         if (rq.size() == 0)
            check(rd_data_q, 64'h1_0000_0000);
         else
            check(rd_data_q, rq.pop_front());
      end
      if (cfg_wr_q === 1'b1)
      begin
         if (cfg_addr_q === 12'h104)
            t_lo = cyc;
         if (wq.size() == 0)
            check(cfg_data_q, 64'h1_0000_0000);
         else
            check({cfg_addr_q, cfg_data_q}, wq.pop_front());
      end
      if (cyc == 30000)
      begin
         failures++;
         summarize;
      end
   end

   initial
   begin
      int seed;
      int da;
      int db;
      int l;
      int r;
      int p;
      logic [3:0] a;
      logic [3:0] b;
      seed = $urandom(32'hb896);
      a = 4'($urandom_range(7));
      b = a + 4'($urandom_range(8, 1));
      boot(a);
      da = t_lo - t0;
      boot(b);
      db = t_lo - t0;
      check(db - da, (b - a) * 3);
      // Pins move after capture; the stored slot must not follow
      slot = ~b;
      rd(12'h104, {mac[23:0], 4'h0, b});
      rd(12'h108, {mac[47:24], 8'h00});
      rd(12'h10c, 32'h0);
      rd(12'h100, 32'h0);
      rd(12'h104, {mac[23:0], 4'h0, b});
      step;
      rd_en = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         hs = 2'(i);
         led_chk(3, hs.prep ? 16 : (hs.safe ? 32 : 0));
      end
      for (int i = 0; i < 4; i++)
      begin
         cl = 2'(i);
         fo = 2'(i);
         led_chk(1, cl.up ? (cl.gen3 ? 32 : 16) : 0);
         led_chk(0, fo.up ? (fo.gen3 ? 32 : 16) : 0);
      end
      fl = '{valid: 1'b0, known: 1'b1, code: 4'h3};
      led_chk(2, 0);
      fl = '{valid: 1'b1, known: 1'b0, code: 4'h3};
      led_chk(2, 32);
      fl = '{valid: 1'b1, known: 1'b1, code: 4'h0};
      led_chk(2, 32);
      for (int n = 1; n < 16; n++)
      begin
         fl.code = 4'(n);
         p = (2 * n + 6) * 4;
         repeat (2 * p) step;
         meas(2, p, l, r);
         check({l, r}, {4 * n, n});
      end
      repeat (3) step;
      check(rq.size() + wq.size(), 0);
      summarize;
   end
endmodule
